/* hw/watchdog_mode_clock_select.sv */
// Watchdog counter with mode control, overflow flag and clock select.
// Assumes one 250 MHz clock, a synchronous active-high reset, and oscillator
// and subclock ticks that arrive as one-cycle enables in the clk_i domain.
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "wdt_defs.svh"

module watchdog_mode_clock_select
    import wdt_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    rst_i,
    input  wire wb_req_t wb_i,
    output wb_rsp_t      wb_o,
    input  wire logic    osc_tick_i,
    input  wire logic    subclk_tick_i,
    input  wire logic    counter_write_enable_i,
    input  wire logic    counter_run_i,
    output logic         internal_reset_o,
    output logic         watchdog_reset_flag_set_o,
    output logic         interval_irq_o
);

    // The mode and interrupt control register keeps the overflow flag in
    // bit 7, the mode in bit 5 and the interrupt enable in bit 3. Bits 6 and 4
    // are write gates that are never stored and always read back as one.
    // The up-counter register is the eight count bits themselves. The clock
    // select register keeps a four-bit source code under four fixed ones.
    // All three sit in byte lane 0, and the upper lanes read zero and ignore
    // writes, so a byte-wide master and a word-wide master see the same map.

    // Register state.
    logic                        overflow_flag;
    timer_mode_t                 timer_mode_select;
    logic                        overflow_irq_enable;
    logic [7:0]                  watchdog_up_counter;
    logic [3:0]                  counter_clock_select;
    logic                        clear_armed;

    // Bus answer registers.
    logic                        ack;
    logic [31:0]                 rdata;

    // Prescalers.
    logic [`WD_PHI_PRE_W-1:0]    phi_pre;
    logic [`WD_SUB_PRE_W-1:0]    sub_pre;
    logic [`WD_PHI_TAPS-1:0]     phi_tick;
    logic [1:0]                  sub_tick;

    // Internal reset sequencer.
    rstreq_state_t               rq_state;
    rstreq_state_t               next_rq_state;
    logic [9:0]                  rq_count;
    logic                        rst_set_pulse;

    // Decode and strobes.
    wire        bus_req     = wb_i.cyc & wb_i.stb;
    wire        lane0       = wb_i.sel[0];
    wire        hit_mode    = (wb_i.adr == `WD_ADR_MODE);
    wire        hit_count   = (wb_i.adr == `WD_ADR_COUNT);
    wire        hit_clksel  = (wb_i.adr == `WD_ADR_CLKSEL);
    wire        access_edge = bus_req & ack;
    wire        wr_edge     = access_edge & wb_i.we & lane0;
    wire        rd_edge     = access_edge & ~wb_i.we;
    wire [7:0]  wbyte       = wb_i.dat[7:0];
    wire        wr_mode     = wr_edge & hit_mode;
    wire        wr_clksel   = wr_edge & hit_clksel;

    // The two gated bits follow the same pattern: the write carries its own
    // permission in the neighbouring bit, so a stray byte write of all ones
    // can change neither the mode nor the interrupt enable.
    // Write-inhibit gates on the two guarded control bits.
    wire        mode_bit_write_inhibit  = wbyte[`WD_MODE_WI_BIT];
    wire        irq_enable_write_inhibit = wbyte[`WD_IEN_WI_BIT];
    wire        mode_load   = wr_mode & ~mode_bit_write_inhibit;
    wire        ien_load    = wr_mode & ~irq_enable_write_inhibit;

    // Counter writes are dropped silently while the write gate is closed.
    // write gate.
    wire        count_load  = wr_edge & hit_count & counter_write_enable_i;

    // Reads need no lane select: the whole word is returned, with the
    // register in the low byte.
    // Read image of each register; unmapped offsets read zero.
    // reserved ones.
    wire [7:0]  mode_image  = {overflow_flag, 1'b1, timer_mode_select,
                               1'b1, overflow_irq_enable, `WD_RSVD_ONES3};
    wire [7:0]  clksel_image = {`WD_RSVD_ONES4, counter_clock_select};
    wire [7:0]  read_byte   = hit_mode   ? mode_image :
                              hit_count  ? watchdog_up_counter :
                              hit_clksel ? clksel_image : 8'h00;

    // One tick per divided system clock period, tap i divides by 64 << i.
    genvar tap;
    generate
        for (tap = 0; tap < `WD_PHI_TAPS; tap = tap + 1) begin : g_phi_tap
            assign phi_tick[tap] = &phi_pre[`WD_PHI_TAP0_W+tap-1:0];
        end
    endgenerate

    // The subclock taps only fire on a subclock tick.
    assign sub_tick[0] = subclk_tick_i & (&sub_pre[`WD_SUB16_W-1:0]);
    assign sub_tick[1] = subclk_tick_i & (&sub_pre);

    // Clock select decode. Reserved 011x codes give no tick, so a counter
    // left on such a code simply stands still rather than running wild.
    // clock source mux.
    wire        count_tick  = counter_clock_select[3] ?
                                  phi_tick[counter_clock_select[2:0]] :
                              counter_clock_select[2] ?
                                  (~counter_clock_select[1] &
                                   sub_tick[counter_clock_select[0]]) :
                                  osc_tick_i;

    // Counting is frozen while the internal reset is being held, since the
    // rest of the chip is held in reset too.
    // run gate.
    wire        count_step  = count_tick & counter_run_i & (rq_state == RQ_IDLE);
    wire        wrap        = count_step & ~count_load &
                              (watchdog_up_counter == `WD_COUNT_MAX);
    wire        wd_overflow = wrap & (timer_mode_select == MODE_WATCHDOG);
    wire        rq_done     = (rq_state == RQ_HOLD) & osc_tick_i &
                              (rq_count == `WD_RST_OSC_TICKS - 10'd1);
    wire        ovf_clear   = wr_mode & ~wbyte[`WD_OVF_BIT] & clear_armed;
    wire        ovf_auto_clr = rq_done;

    // Bus answer: ack follows the request by one cycle and drops after one.
    // The answer is registered, so every access costs one wait state; in
    // return the read mux never sits in the path from the bus to the master.
    // A master that keeps its strobe up after the ack starts a second
    // access, which is harmless for a read and repeats a write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack   <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack   <= bus_req & ~ack;
            rdata <= {24'h00_0000, read_byte};
        end
    end

    // Bus outputs come straight from the answer flip-flops.
    assign wb_o.ack = ack;
    assign wb_o.dat = rdata;

    // Free-running system clock prescaler.
    // It is never cleared by a register write, so the first tick after a
    // clock select change comes anywhere within one period of the new tap.
    // Software that needs an exact first interval must allow for one tick
    // of slack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phi_pre <= '0;
        end else begin
            phi_pre <= phi_pre + 1'b1;
        end
    end

    // Subclock prescaler advances only on subclock ticks.
    // Subclock ticks are taken as enables already aligned to clk_i; a tick
    // that is wider than one cycle would be counted more than once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sub_pre <= '0;
        end else if (subclk_tick_i) begin
            sub_pre <= sub_pre + 1'b1;
        end
    end

    // Changing the mode while the counter runs can disturb the count, so
    // software stops the counter before it switches.
    // Mode select and its write-inhibit.
    // mode storage.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_mode_select <= MODE_WATCHDOG;
        end else if (mode_load) begin
            timer_mode_select <= timer_mode_t'(wbyte[`WD_MODE_BIT]);
        end
    end

    // Overflow interrupt enable. It is kept in watchdog mode too, so it takes
    // effect again as soon as interval mode is chosen.
    // enable storage.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_irq_enable <= 1'b0;
        end else if (ien_load) begin
            overflow_irq_enable <= wbyte[`WD_IEN_BIT];
        end
    end

    // Clock select register. Codes 00xx take the oscillator tick, 0100 and
    // 0101 the two subclock taps, and 1000 to 1111 the system clock taps in
    // rising order of division.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_clock_select <= `WD_CLKSEL_RST;
        end else if (wr_clksel) begin
            counter_clock_select <= wbyte[3:0];
        end
    end

    // Because a load beats a step, a write that lands in the cycle of a wrap
    // suppresses that overflow entirely; a reload in time is exactly what a
    // watchdog is waiting for.
    // The counter: a load beats a step in the same cycle, and the end of
    // the internal reset puts it back to its reset value.
    // up-counter.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_up_counter <= `WD_COUNT_RST;
        end else if (count_load) begin
            watchdog_up_counter <= wbyte;
        end else if (rq_done) begin
            watchdog_up_counter <= `WD_COUNT_RST;
        end else if (count_step) begin
            watchdog_up_counter <= watchdog_up_counter + 8'h01;
        end
    end

    // Three events touch the flag: a wrap sets it, a software clear after an
    // arming read drops it, and the end of an internal reset hold drops it.
    // Only the set is allowed to win a collision.
    // Overflow flag. A wrap in the same cycle as a clear still sets it, so
    // an overflow that races the handler is never lost.
    // flag set.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (ovf_clear | ovf_auto_clr) begin
            overflow_flag <= 1'b0;
        end
    end

    // The arming is lost whenever the flag goes low, so a stale arming can
    // never clear a later overflow that software has not yet read.
    // Arming: a read that sees the flag set permits the next zero write to
    // clear it. Any write to the register uses up the arming.
    // read arming.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_armed <= 1'b0;
        end else if (rd_edge & hit_mode & overflow_flag) begin
            clear_armed <= 1'b1;
        end else if (wr_mode | ~overflow_flag) begin
            clear_armed <= 1'b0;
        end
    end

    // The sequencer has two states: idle, and holding the internal reset.
    // A wrap in interval mode never leaves idle.
    // Internal reset sequencer next state.
    always_comb begin
        next_rq_state = rq_state;
        case (rq_state)
            RQ_IDLE: begin
                if (wd_overflow) begin
                    next_rq_state = RQ_HOLD;
                end
            end
            RQ_HOLD: begin
                if (rq_done) begin
                    next_rq_state = RQ_IDLE;
                end
            end
            default: begin
                next_rq_state = RQ_IDLE;
            end
        endcase
    end

    // Hold counter counts oscillator ticks while the reset is out.
    // The hold is counted in oscillator ticks rather than clock cycles, so
    // its length follows the oscillator and not the system clock rate.
    // Ten bits are enough, since the count never passes 512.
    // hold length.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rq_state <= RQ_IDLE;
            rq_count <= 10'd0;
        end else begin
            rq_state <= next_rq_state;
            if (rq_state == RQ_IDLE) begin
                rq_count <= 10'd0;
            end else if (osc_tick_i) begin
                rq_count <= rq_count + 10'd1;
            end
        end
    end

    // Flag-set pulse towards the first control register.
    // The pulse lasts one cycle, since the first control register keeps the
    // flag itself. A hold in progress cannot raise a second pulse, because
    // counting stands still until the hold ends.
    // reset flag pulse.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_set_pulse <= 1'b0;
        end else begin
            rst_set_pulse <= wd_overflow;
        end
    end

    // Outputs towards the reset controller and the first control register.
    assign watchdog_reset_flag_set_o = rst_set_pulse;
    assign internal_reset_o          = (rq_state == RQ_HOLD);

    // Software that leaves the enable low may still poll the flag in
    // interval mode and clear it in the same way.
    // The interrupt is a level that lasts until software clears the flag;
    // it never fires in watchdog mode, where the reset takes over.
    // interrupt gating.
    assign interval_irq_o = overflow_flag & overflow_irq_enable &
                            (timer_mode_select == MODE_INTERVAL);

endmodule // watchdog_mode_clock_select

/* hw/wdt_defs.svh */
// Constants of the watchdog block: register offsets, field positions,
// reset values and counts.
// Assumes a 32-bit classic Wishbone slave with the registers in byte lane 0.
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// Byte offsets of the three registers.
`define WD_ADR_MODE      8'h00
`define WD_ADR_COUNT     8'h04
`define WD_ADR_CLKSEL    8'h08

// Field positions of the mode and interrupt control register.
`define WD_OVF_BIT       7
`define WD_MODE_WI_BIT   6
`define WD_MODE_BIT      5
`define WD_IEN_WI_BIT    4
`define WD_IEN_BIT       3

// Reset values, fixed read-back bits and the counter maximum.
`define WD_COUNT_RST     8'h00
`define WD_CLKSEL_RST    4'h0
`define WD_RSVD_ONES3    3'h7
`define WD_RSVD_ONES4    4'hf
`define WD_COUNT_MAX     8'hff

// Internal reset length, in ticks of the on-chip oscillator.
`define WD_RST_OSC_TICKS 10'd512

// Prescaler widths: system clock taps /64 to /8192, subclock /16 and /256.
`define WD_PHI_PRE_W     13
`define WD_PHI_TAPS      8
`define WD_PHI_TAP0_W    6
`define WD_SUB_PRE_W     8
`define WD_SUB16_W       4

`endif

/* hw/wdt_pkg.sv */
// Types shared by the watchdog block and its bench.
// Assumes the constants header is compiled alongside.
package wdt_pkg;

    // Wishbone request from the master.
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    // Wishbone answer from this slave.
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Counting mode.
    typedef enum logic [0:0] {
        MODE_WATCHDOG = 1'b0,
        MODE_INTERVAL = 1'b1
    } timer_mode_t;

    // Internal reset request sequencer.
    typedef enum logic [0:0] {
        RQ_IDLE = 1'b0,
        RQ_HOLD = 1'b1
    } rstreq_state_t;

endpackage

/* verification/watchdog_mode_clock_select_chk.sv */
// Port-level assertions for the watchdog mode and clock select block.
// Assumes the package and constants header are compiled first; bound below.
`timescale 1ns/10ps
`include "wdt_defs.svh"

module watchdog_mode_clock_select_chk
    import wdt_pkg::*;
(
    input  wire logic    clk_i,
    input  wire logic    rst_i,
    input  wire wb_req_t wb_i,
    input  wire wb_rsp_t wb_o,
    input  wire logic    osc_tick_i,
    input  wire logic    subclk_tick_i,
    input  wire logic    counter_write_enable_i,
    input  wire logic    counter_run_i,
    input  wire logic    internal_reset_o,
    input  wire logic    watchdog_reset_flag_set_o,
    input  wire logic    interval_irq_o
);
    logic [9:0] ticks;
    logic [9:0] next_ticks;
    logic       mode_wr;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Oscillator ticks seen during a hold; the count restarts once the hold ends.
    assign next_ticks = internal_reset_o ? ticks + {9'h0, osc_tick_i} : 10'h0;
    assign mode_wr    = wb_o.ack && wb_i.we && (wb_i.adr == `WD_ADR_MODE);
    always_ff @(posedge clk_i) begin
        ticks <= rst_i ? 10'h0 : next_ticks;
    end

    // A watchdog wrap starts the hold and pulses the flag for one cycle only.
    sequence wd_wrap_s;
        watchdog_reset_flag_set_o && internal_reset_o ##1 !watchdog_reset_flag_set_o;
    endsequence

    // Bus answers, read-back of fixed bits and overflow outputs.
    ack_next_a: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
        else $error("ack missing after request");
    ack_pulse_a: assert property (wb_o.ack |=> !wb_o.ack)
        else $error("ack longer than one cycle");
    mode_ones_a:
        assert property (wb_o.ack && !wb_i.we && wb_i.adr == `WD_ADR_MODE
            |-> wb_o.dat[6] && wb_o.dat[4] && wb_o.dat[2:0] == 3'h7) else $error("mode fixed bits");
    clksel_ones_a:
        assert property (wb_o.ack && !wb_i.we && wb_i.adr == `WD_ADR_CLKSEL
            |-> wb_o.dat[31:4] == 28'hf) else $error("clock select fixed bits");
    irq_hold_a:
        assert property (interval_irq_o && !mode_wr |=> interval_irq_o) else $error("irq dropped");
    irq_wd_a:
        assert property (watchdog_reset_flag_set_o |-> !interval_irq_o) else $error("irq in watchdog");
    wrap_start_a:
        assert property ($rose(internal_reset_o) |-> wd_wrap_s) else $error("wrap sequence");
    flag_cause_a:
        assert property (watchdog_reset_flag_set_o |-> $rose(internal_reset_o))
            else $error("flag pulse without new hold");
    hold_len_a:
        assert property (internal_reset_o && next_ticks < 10'd512 |=> internal_reset_o)
            else $error("hold too short");
    hold_max_a:
        assert property (internal_reset_o |-> ticks < 10'd512) else $error("hold too long");
endmodule // watchdog_mode_clock_select_chk

bind watchdog_mode_clock_select watchdog_mode_clock_select_chk i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .osc_tick_i(osc_tick_i),
    .subclk_tick_i(subclk_tick_i), .counter_write_enable_i(counter_write_enable_i),
    .counter_run_i(counter_run_i), .internal_reset_o(internal_reset_o),
    .watchdog_reset_flag_set_o(watchdog_reset_flag_set_o), .interval_irq_o(interval_irq_o));

/* verification/tb_watchdog_mode_clock_select.sv */
// Self-checking bench for the watchdog mode and clock select block.
// Drives the register bus, tick enables and control levels itself.
`timescale 1ns/10ps
`include "wdt_defs.svh"

module tb_watchdog_mode_clock_select
    import wdt_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    wb_req_t     req   = '0;
    wb_rsp_t     rsp;
    logic        osc   = 1'b1;
    logic        sub   = 1'b0;
    logic        cwe   = 1'b0;
    logic        run   = 1'b0;
    logic        int_rst;
    logic        flag;
    logic        irq;
    logic [31:0] rd;
    logic [3:0]  lanes = 4'h1;
    int          errors = 0;
    int          total_checks = 0;

    // Clock; oscillator and subclock tick on alternate cycles, so a reset hold
    // counted in cycles instead of oscillator ticks shows up as half length.
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) sub <= ~sub;
    always @(posedge clk_i) osc <= ~osc;

    watchdog_mode_clock_select i_watchdog_mode_clock_select (
        .clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_o(rsp), .osc_tick_i(osc),
        .subclk_tick_i(sub), .counter_write_enable_i(cwe), .counter_run_i(run),
        .internal_reset_o(int_rst), .watchdog_reset_flag_set_o(flag), .interval_irq_o(irq));

    // Verdict and end of run.
    task automatic end_sim;
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Comparisons of register values and of output pins.
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic e, input logic g);
        chk_reg(nm, {31'h0, e}, {31'h0, g});
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        int n;
        n = 0;
        req <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:lanes, dat:{24'h0, wd}};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 16);
        rd = rsp.dat;
        req <= '0;
        @(posedge clk_i);
        if (n >= 16) begin
            errors++;
            end_sim();
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] adr, input logic [31:0] e);
        wb_cycle(1'b0, adr, 8'h00);
        chk_reg(nm, e, rd);
    endtask

    // A wait that used up its bound is a mismatch and ends the run.
    task automatic bound_chk(input logic stuck);
        if (stuck) begin
            errors++;
            end_sim();
        end
    endtask

    // Reset values, then the write-inhibit pairs of the mode register.
    task automatic reset_and_inhibit;
        rd_chk("mode", `WD_ADR_MODE, 32'h57);
        rd_chk("count", `WD_ADR_COUNT, 32'h00);
        rd_chk("clksel", `WD_ADR_CLKSEL, 32'hf0);
        rd_chk("unmapped", 8'h0c, 32'h00);
        lanes = 4'h0;
        wb_cycle(1'b1, `WD_ADR_CLKSEL, 8'h0b);
        lanes = 4'h1;
        rd_chk("clksel", `WD_ADR_CLKSEL, 32'hf0);
        wb_cycle(1'b1, `WD_ADR_MODE, 8'hc8);
        rd_chk("mode", `WD_ADR_MODE, 32'h5f);
        wb_cycle(1'b1, `WD_ADR_MODE, 8'h30);
        rd_chk("mode", `WD_ADR_MODE, 32'h7f);
        wb_cycle(1'b1, `WD_ADR_MODE, 8'h40);
        rd_chk("mode", `WD_ADR_MODE, 32'h77);
        wb_cycle(1'b1, `WD_ADR_COUNT, 8'h55);
        rd_chk("count", `WD_ADR_COUNT, 32'h00);
        cwe <= 1'b1;
        wb_cycle(1'b1, `WD_ADR_COUNT, 8'hfe);
        rd_chk("count", `WD_ADR_COUNT, 32'hfe);
    endtask

    // Interval overflow with the interrupt masked, then enabled and cleared.
    task automatic interval_overflow;
        int n;
        n = 0;
        run <= 1'b1;
        do begin
            wb_cycle(1'b0, `WD_ADR_MODE, 8'h00);
            n++;
        end while (rd[7] !== 1'b1 && n < 16);
        bound_chk(rd[7] !== 1'b1);
        run <= 1'b0;
        chk_reg("mode", 32'hf7, rd);
        chk_pin("irq", 1'b0, irq);
        wb_cycle(1'b1, `WD_ADR_MODE, 8'hc8);
        chk_pin("irq", 1'b1, irq);
        wb_cycle(1'b1, `WD_ADR_MODE, 8'h70);
        chk_pin("irq", 1'b1, irq);
        rd_chk("mode", `WD_ADR_MODE, 32'hff);
        wb_cycle(1'b1, `WD_ADR_MODE, 8'h70);
        chk_pin("irq", 1'b0, irq);
        rd_chk("mode", `WD_ADR_MODE, 32'h7f);
    endtask

    // Watchdog overflow: reset hold, flag pulse, and the state left behind.
    task automatic watchdog_overflow;
        int n;
        wb_cycle(1'b1, `WD_ADR_MODE, 8'h10);
        wb_cycle(1'b1, `WD_ADR_COUNT, 8'hff);
        run <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (flag !== 1'b1 && n < 16);
        bound_chk(flag !== 1'b1);
        run <= 1'b0;
        chk_pin("int_rst", 1'b1, int_rst);
        chk_pin("irq", 1'b0, irq);
        @(posedge clk_i);
        chk_pin("flag", 1'b0, flag);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (int_rst === 1'b1 && n < 1200);
        bound_chk(int_rst !== 1'b0);
        // Two cycles per oscillator tick; counting starts two edges after the wrap.
        chk_pin("hold", 1'b1, n >= 1022 && n <= 1024);
        rd_chk("mode", `WD_ADR_MODE, 32'h5f);
        rd_chk("count", `WD_ADR_COUNT, 32'h00);
    endtask

    // Every permitted clock select code: counts over a window of two periods of its tap.
    task automatic clock_select;
        int d;
        for (int c = 0; c < 16; c++) begin
            if (c == 6 || c == 7) continue;
            d = c < 4 ? 2 : c == 4 ? 32 : c == 5 ? 512 : 64 << (c - 8);
            wb_cycle(1'b1, `WD_ADR_CLKSEL, 8'(c));
            wb_cycle(1'b1, `WD_ADR_COUNT, 8'h00);
            rd_chk("clksel", `WD_ADR_CLKSEL, {24'h0, 4'hf, 4'(c)});
            run <= 1'b1;
            repeat (2 * d) @(posedge clk_i);
            run <= 1'b0;
            rd_chk("count", `WD_ADR_COUNT, 32'h2);
        end
    endtask

    // Reset, then the scenarios in order.
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        reset_and_inhibit();
        interval_overflow();
        watchdog_overflow();
        clock_select();
        end_sim();
    end
endmodule // tb_watchdog_mode_clock_select
